// ==== core/cjk_pkg.sv ====
// Package: constants, register map and types for the cascade JK sync checker
package cjk_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam int            CJK_REG_COUNT    = 64;
  localparam int            CJK_REG_WIDTH    = 8;
  localparam logic [5:0]    CJK_ADDR_MODE    = 6'h00;
  localparam logic [5:0]    CJK_ADDR_RCV_B   = 6'h0A;
  localparam int            CJK_MODE_RUN_BIT = 0;
  localparam int            CJK_MODE_CAS_BIT = 3;
  localparam int            CJK_RCV_B_CSE    = 4;
  localparam logic [7:0]    CJK_MODE_RESET   = 8'h00;
  localparam logic          CJK_CSE_RESET    = 1'b0;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int            CJK_CLK_PERIOD_NS = 10;
  localparam int            CJK_START_WIN_NS  = 80;
  localparam int            CJK_START_WIN_CYC = CJK_START_WIN_NS / CJK_CLK_PERIOD_NS;
  localparam int            CJK_MAX_JK        = 2;
  localparam int            CJK_FIFO_DEPTH    = 8;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       isJk;
    logic       isEnd;
  } cjk_sym_t;

  typedef enum logic [1:0] {
    ST_HUNT,
    ST_WAIT,
    ST_RUN
  } cjk_state_t;

endpackage : cjk_pkg

// ==== core/cjk_sync_checker.sv ====
// Cascade JK alignment, cascade-ready control, sync error flag and host FIFO
// Notes on behaviour
// R1: Sender keeps frames at least three bytes.
// R2: Sender frames up to 4500 bytes, JK..T/R/S.
// R3: JK arrival skew across devices within 80ns.
// R4: First JK passes to host, releases ready.
// R5: At most two consecutive JK pairs presented.
// R6: Cascade start high only after all release.
// R7: Set sync error if start late.
// R8: Peers raise cascade start within about 80ns.
// R9: Corrupted JK may go unreported as error.
// R10: Sender leaves eight idle pairs between frames.
// R11: Works with four idle pairs between frames.
// R12: Sixty-four eight-bit registers on control bus.
// R13: Ready output is open drain, wired AND.
// R14: Sender launches all streams together with JK.
// R15: Host trusts data only after cascade start.

// ------------------------------------------------------------------------------
// Parameterised FIFO
// ------------------------------------------------------------------------------
module cjk_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             full;
  logic             empty;

  assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty    = (wrPtr_q == rdPtr_q);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_q <= '0;
    end else if (inValid && !full) begin
      wrPtr_q <= wrPtr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdPtr_q <= '0;
    end else if (outReady && !empty) begin
      rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
    (wrPtr_q - rdPtr_q) <= (AW + 1)'(DEPTH))
    else $error("FIFO holds more words than its depth");
endmodule : cjk_fifo

// ------------------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------------------
module cjk_sync_checker #(
  parameter int FIFO_DEPTH = cjk_pkg::CJK_FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              rxValid,
  output logic                   rxReady,
  input  wire cjk_pkg::cjk_sym_t rxSym,
  output logic                   hostValid,
  input  wire logic              hostReady,
  output cjk_pkg::cjk_sym_t      hostSym,
  output logic                   hostCascadeStart,
  output logic                   cascadeReadyOut,
  output logic                   cascadeReadyOe,
  input  wire logic              cascadeStartIn,
  input  wire logic [5:0]        cbAddr,
  input  wire logic              cbRead,
  input  wire logic              cbWrite,
  input  wire logic [7:0]        cbWdata,
  output logic      [7:0]        cbRdata,
  output logic                   cbAck
);
  import cjk_pkg::*;

  cjk_state_t state_q;
  cjk_state_t state_d;
  logic [1:0] jkCount_q;
  logic [3:0] timer_q;
  logic       errArmed_q;
  logic [7:0] mode_q;
  logic       cse_q;
  logic       csS1_q;
  logic       csS2_q;
  logic       csS3_q;
  logic       csStable_q;
  logic       take;
  logic       push;
  logic       fifoReady;
  logic       cascadeEn;
  logic       lateStart;
  logic       cseWrClr;

  assign cascadeEn = mode_q[CJK_MODE_RUN_BIT] && mode_q[CJK_MODE_CAS_BIT];
  assign rxReady   = fifoReady;
  assign take      = rxValid && fifoReady;

  // ----------------------------------------------------------------------------
  // Cascade start pin synchroniser
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      csS1_q <= 1'b0;
      csS2_q <= 1'b0;
      csS3_q <= 1'b0;
    end else begin
      csS1_q <= cascadeStartIn;
      csS2_q <= csS1_q;
      csS3_q <= csS2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      csStable_q <= 1'b0;
    end else if (csS2_q == csS3_q) begin
      csStable_q <= csS3_q;                                              // [R6]
    end
  end

  assign hostCascadeStart = csStable_q;                                  // [R15]

  // ----------------------------------------------------------------------------
  // Alignment state machine
  // ----------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    push    = 1'b0;
    case (state_q)
      ST_HUNT: begin
        if (take && cascadeEn && rxSym.isJk) begin                       // [R9]
          push    = 1'b1;                                                // [R4]
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        push = take && (!rxSym.isJk || jkCount_q < 2'(CJK_MAX_JK));      // [R5]
        if (take && rxSym.isEnd) begin
          state_d = ST_HUNT;                                             // [R11]
        end else if (csStable_q) begin
          state_d = ST_RUN;                                              // [R6]
        end
      end
      ST_RUN: begin
        push = take;
        if (take && rxSym.isEnd) begin
          state_d = ST_HUNT;                                             // [R11]
        end
      end
      default: begin
        state_d = ST_HUNT;
      end
    endcase
    if (!cascadeEn) begin
      state_d = ST_HUNT;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_HUNT;
    end else begin
      state_q <= state_d;
    end
  end

  // Counts JK pairs handed to the host since the ready line was released
  always_ff @(posedge clk) begin
    if (reset) begin
      jkCount_q <= 2'h0;
    end else if (state_q == ST_HUNT) begin
      jkCount_q <= push ? 2'h1 : 2'h0;                                   // [R4]
    end else if (push && rxSym.isJk) begin
      jkCount_q <= jkCount_q + 2'h1;                                     // [R5]
    end
  end

  // Wired-AND ready line: pulled low while hunting for JK
  assign cascadeReadyOut = 1'b0;
  assign cascadeReadyOe  = cascadeEn && (state_q == ST_HUNT);            // [R13]

  // ----------------------------------------------------------------------------
  // Cascade start window and sync error
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_q <= 4'h0;
    end else if (state_q != ST_WAIT) begin
      timer_q <= 4'h0;
    end else if (timer_q != 4'(CJK_START_WIN_CYC)) begin
      timer_q <= timer_q + 4'h1;                                         // [R7]
    end
  end

  assign lateStart = (state_q == ST_WAIT) && errArmed_q && !csStable_q
                     && (timer_q == 4'(CJK_START_WIN_CYC - 1));          // [R7]

  always_ff @(posedge clk) begin
    if (reset) begin
      errArmed_q <= 1'b0;
    end else if (state_q == ST_HUNT) begin
      errArmed_q <= 1'b1;
    end else if (lateStart) begin
      errArmed_q <= 1'b0;
    end
  end

  // Written zero clears the flag; a new event in the same cycle wins
  assign cseWrClr = cbWrite && (cbAddr == CJK_ADDR_RCV_B) && !cbWdata[CJK_RCV_B_CSE];
  always_ff @(posedge clk) begin
    if (reset) begin
      cse_q <= CJK_CSE_RESET;
    end else if (lateStart) begin
      cse_q <= 1'b1;                                                     // [R7]
    end else if (cseWrClr) begin
      cse_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Control bus registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= CJK_MODE_RESET;
    end else if (cbWrite && cbAddr == CJK_ADDR_MODE) begin
      mode_q <= cbWdata;                                                 // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cbRdata <= 8'h00;
      cbAck   <= 1'b0;
    end else begin
      cbAck <= cbRead || cbWrite;                                        // [R12]
      if (cbRead) begin
        case (cbAddr)
          CJK_ADDR_MODE:  cbRdata <= mode_q;
          CJK_ADDR_RCV_B: cbRdata <= 8'(cse_q) << CJK_RCV_B_CSE;
          default:        cbRdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Host FIFO
  // ----------------------------------------------------------------------------
  cjk_fifo #(
    .WIDTH ($bits(cjk_sym_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .inValid  (push),
    .inReady  (fifoReady),
    .inData   (rxSym),
    .outValid (hostValid),
    .outReady (hostReady),
    .outData  (hostSym)
  );

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  jk_limit_a: assert property (@(posedge clk) disable iff (reset)       // [R5]
    (state_q == ST_WAIT && take && rxSym.isJk && jkCount_q == 2'h2) |-> !push)
    else $error("Third consecutive JK passed to host");

  first_jk_a: assert property (@(posedge clk) disable iff (reset)       // [R4]
    (state_q == ST_HUNT && cascadeEn && take && rxSym.isJk)
    |-> push ##1 (!cascadeReadyOe || !cascadeEn))
    else $error("First JK not passed or ready not released");

  ready_low_a: assert property (@(posedge clk) disable iff (reset)      // [R13]
    (cascadeEn && state_q == ST_HUNT) |-> cascadeReadyOe && !cascadeReadyOut)
    else $error("Ready line not pulled low while hunting");

  late_start_a: assert property (@(posedge clk) disable iff (reset)     // [R7]
    (state_q == ST_HUNT ##1 (state_q == ST_WAIT && !csStable_q && cascadeEn)[*8])
    |=> cse_q)
    else $error("Late cascade start not flagged");

  cse_hold_a: assert property (@(posedge clk) disable iff (reset)       // [R7]
    (cse_q && !cseWrClr) |=> cse_q)
    else $error("Sync error flag lost without a clear");

  run_start_a: assert property (@(posedge clk) disable iff (reset)      // [R6]
    (state_q != ST_RUN ##1 state_q == ST_RUN) |-> $past(csStable_q))
    else $error("Data phase entered before cascade start");

  cs_sync_a: assert property (@(posedge clk) disable iff (reset)        // [R6]
    cascadeStartIn [*4] |=> csStable_q)
    else $error("Cascade start not seen after stable pin");

  bus_ack_a: assert property (@(posedge clk) disable iff (reset)        // [R12]
    (cbRead || cbWrite) |=> cbAck)
    else $error("Control bus access not acknowledged");

  frame_end_a: assert property (@(posedge clk) disable iff (reset)      // [R11]
    (state_q != ST_HUNT && take && rxSym.isEnd) |=> state_q == ST_HUNT)
    else $error("Frame end did not return to hunting");

  sync_run_c: cover property (@(posedge clk) disable iff (reset)
    state_q == ST_WAIT ##1 state_q == ST_RUN);

  sync_err_c: cover property (@(posedge clk) disable iff (reset)
    !cse_q ##1 cse_q);

  second_jk_c: cover property (@(posedge clk) disable iff (reset)
    state_q == ST_WAIT && push && rxSym.isJk && jkCount_q == 2'h1);
endmodule : cjk_sync_checker

// ==== verification/cjk_peer_model.sv ====
// Peer cascaded devices and the wired-AND ready line
module cjk_peer_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       cascadeReadyOe,
  input  wire logic       cascadeReadyOut,
  input  wire logic [3:0] peerDelay,
  input  wire logic       peerStuck,
  output logic            cascadeStartIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       peerOe_q;
  logic       devPull;

  // Open drain: the device only pulls the line while enabled and driving low
  assign devPull = cascadeReadyOe && !cascadeReadyOut;

  // ----
  // Peers release a few cycles after this device
  // ----
  always_ff @(posedge clk) begin
    if (reset || devPull) begin
      cnt_q    <= 4'h0;
      peerOe_q <= 1'b1;
    end else if (!peerStuck) begin
      if (cnt_q == peerDelay) peerOe_q <= 1'b0;
      else cnt_q <= cnt_q + 4'h1;
    end
  end

  // Pulled up, low while any party pulls it
  assign cascadeStartIn = !(devPull || peerOe_q);
endmodule : cjk_peer_model

// ==== verification/cjk_sync_checker_tb.sv ====
// Testbench for the cascade JK sync checker
module cjk_sync_checker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cjk_pkg::*;
  logic       clk, reset, rxValid, rxReady, hostValid, hostReady, hostCascadeStart;
  logic       cascadeReadyOut, cascadeReadyOe, cascadeStartIn, cbRead, cbWrite, cbAck;
  logic       peerStuck;
  logic [5:0] cbAddr;
  logic [7:0] cbWdata, cbRdata;
  logic [3:0] peerDelay;
  cjk_sym_t   rxSym, hostSym, jk, e;
  cjk_sym_t   expQ[$], gotQ[$];
  int         n_errors, checks_done;

  cjk_sync_checker uut (.clk(clk), .reset(reset), .rxValid(rxValid), .rxReady(rxReady),
    .rxSym(rxSym), .hostValid(hostValid), .hostReady(hostReady), .hostSym(hostSym),
    .hostCascadeStart(hostCascadeStart), .cascadeReadyOut(cascadeReadyOut),
    .cascadeReadyOe(cascadeReadyOe), .cascadeStartIn(cascadeStartIn), .cbAddr(cbAddr),
    .cbRead(cbRead), .cbWrite(cbWrite), .cbWdata(cbWdata), .cbRdata(cbRdata), .cbAck(cbAck));
  cjk_peer_model peer (.clk(clk), .reset(reset), .cascadeReadyOe(cascadeReadyOe),
    .cascadeReadyOut(cascadeReadyOut), .peerDelay(peerDelay), .peerStuck(peerStuck),
    .cascadeStartIn(cascadeStartIn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Host side collects every popped word
  always @(posedge clk) begin
    if (!reset && hostValid === 1'b1 && hostReady === 1'b1) gotQ.push_back(hostSym);
  end

  // ----
  // Tasks
  // ----
  task close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task chk(input logic [15:0] g, input logic [15:0] x);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task cb(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    cbAddr = a;
    cbWdata = d;
    cbWrite = wr;
    cbRead = !wr;
    @(negedge clk);
    cbWrite = 1'b0;
    cbRead = 1'b0;
    n = 0;
    while (cbAck !== 1'b1) begin
      if (++n > 4) begin
        chk(16'h0, 16'h1);
        close_out;
      end
      @(negedge clk);
    end
    r = cbRdata;
    // Idle cycle so a following call never re-raises a strobe in this time step
    @(negedge clk);
  endtask : cb

  task rd(input logic [5:0] a, input logic [7:0] x);
    logic [7:0] r;
    cb(1'b0, a, 8'h00, r);
    chk(16'(r), 16'(x));
  endtask : rd

  task wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    cb(1'b1, a, d, r);
  endtask : wr

  task send(input cjk_sym_t s);
    int n;
    rxSym = s;
    rxValid = 1'b1;
    n = 0;
    while (rxReady !== 1'b1) begin
      if (++n > 50) begin
        chk(16'h0, 16'h1);
        close_out;
      end
      @(negedge clk);
    end
    @(negedge clk);
  endtask : send

  function automatic cjk_sym_t sym(input logic [7:0] d, input logic j, input logic x);
    return {d, j, x};
  endfunction : sym

  initial begin
    repeat (20000) @(posedge clk);
    chk(16'h0, 16'h1);
    close_out;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rxValid = 1'b0;
    rxSym = '0;
    hostReady = 1'b0;
    cbAddr = 6'h00;
    cbWdata = 8'h00;
    cbRead = 1'b0;
    cbWrite = 1'b0;
    peerDelay = 4'h0;
    peerStuck = 1'b0;
    reset = 1'b1;
    n_errors = 0;
    checks_done = 0;
    void'($urandom(32'h62E4));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    rd(CJK_ADDR_RCV_B, 8'h00);
    rd(CJK_ADDR_MODE, CJK_MODE_RESET);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    wr(CJK_ADDR_MODE, 8'h09);
    rd(CJK_ADDR_MODE, 8'h09);
    chk(16'(cascadeReadyOe), 16'h1);
    chk(16'(cascadeReadyOut), 16'h0);
    $display("test registers done");
    peerDelay = 4'($urandom_range(1, 0));
    jk = sym(8'($urandom), 1'b1, 1'b0);
    repeat (8) send(sym(8'($urandom), 1'b0, 1'b0));
    send(jk);
    chk(16'(cascadeReadyOe), 16'h0);
    send(jk);
    send(jk);
    expQ = {jk, jk};
    rxValid = 1'b0;
    for (int i = 0; i < 12 && hostCascadeStart !== 1'b1; i++) @(negedge clk);
    chk(16'(hostCascadeStart), 16'h1);
    for (int i = 0; i < 6; i++) begin
      e = sym(8'($urandom), 1'b0, 1'b0);
      send(e);
      expQ.push_back(e);
    end
    chk(16'(rxReady), 16'h0);
    e = sym(8'($urandom), 1'b0, 1'b1);
    hostReady = 1'b1;
    send(e);
    expQ.push_back(e);
    rxValid = 1'b0;
    repeat (14) @(negedge clk);
    chk(16'(gotQ.size()), 16'd9);
    for (int i = 0; i < 9 && i < gotQ.size(); i++) chk(16'(gotQ[i]), 16'(expQ[i]));
    chk(16'(cascadeReadyOe), 16'h1);
    rd(CJK_ADDR_RCV_B, 8'h00);
    $display("test prompt frame done");
    gotQ.delete();
    repeat (4) send(sym(8'($urandom), 1'b0, 1'b0));
    peerStuck = 1'b1;
    send(jk);
    rxValid = 1'b0;
    repeat (12) @(negedge clk);
    chk(16'(hostCascadeStart), 16'h0);
    rd(CJK_ADDR_RCV_B, 8'h10);
    chk(16'(gotQ.size()), 16'd1);
    send(e);
    rxValid = 1'b0;
    peerStuck = 1'b0;
    rd(CJK_ADDR_RCV_B, 8'h10);
    wr(CJK_ADDR_RCV_B, 8'h00);
    rd(CJK_ADDR_RCV_B, 8'h00);
    $display("test late start done");
    wr(CJK_ADDR_MODE, 8'h01);
    chk(16'(cascadeReadyOe), 16'h0);
    gotQ.delete();
    send(jk);
    rxValid = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(gotQ.size()), 16'd0);
    chk(16'(hostValid), 16'h0);
    $display("test cascade off done");
    close_out;
  end
endmodule : cjk_sync_checker_tb
